// ---- core/msp_pkg.sv ----
// Purpose: Shared constants and types of the modem serial control port
// Assumes: One core clock; serial pins arrive asynchronously
// Notes:   Offsets, field positions and reset values are named here once
package msp_pkg;
    localparam int          ADDR_W                  = 6;   // Resource address width
    localparam int          DATA_W                  = 16;  // Payload word width
    localparam int          HDR_RW_BIT              = 7;   // Read flag position in header
    localparam int          XTAL_TRIM_MSB           = 15;  // Crystal trim field top bit
    localparam int          XTAL_TRIM_LSB           = 8;   // Crystal trim field low bit
    localparam int          CLOCK_OUT_PIN_RATE_MSB           = 2;   // Clock-out rate field top bit
    localparam int          CLOCK_OUT_PIN_RATE_LSB           = 0;   // Clock-out rate field low bit
    localparam logic [5:0]  CLOCK_OUT_CONTROL_OFFSET = 6'h0a;
    localparam logic [15:0] CLOCK_OUT_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] REGFILE_RESET           = 16'h0000;
    localparam logic [2:0]  CLOCK_OUT_PIN_RATE_UNDIVIDED     = 3'h0;
    localparam logic [3:0]  HDR_LAST_BIT            = 4'h7;
    localparam logic [3:0]  WORD_LAST_BIT           = 4'hf;

    // Transaction phases
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_HEADER = 2'b01,
        ST_WRITE  = 2'b10,
        ST_READ   = 2'b11
    } msp_state_type;

    // True when an address selects the clock-out control register
    function automatic logic msp_is_clock_ctl(input logic [5:0] addr);
        msp_is_clock_ctl = (addr == CLOCK_OUT_CONTROL_OFFSET);
    endfunction : msp_is_clock_ctl
endpackage : msp_pkg

// ---- core/msp_regfile.sv ----
// Purpose: Internal resource memory reached through the serial port
// Assumes: One write port and one read port, both on the core clock
// Notes:   Read data come out of a register one cycle after the request
module msp_regfile
    import msp_pkg::*;
#(
    parameter int AW = ADDR_W,                  // Address width
    parameter int DW = DATA_W                   // Word width
) (
    input  wire logic          clock,           // Core clock
    input  wire logic          rst,             // Async reset, active high
    input  wire logic          wr_en,           // Write strobe
    input  wire logic [AW-1:0] wr_addr,         // Write address
    input  wire logic [DW-1:0] wr_data,         // Write data
    input  wire logic          rd_en,           // Read strobe
    input  wire logic [AW-1:0] rd_addr,         // Read address
    output logic      [DW-1:0] rd_data_q        // Registered read data
);
    logic [DW-1:0] mem_q [0:(1<<AW)-1];
    logic [DW-1:0] rd_data_d;

    // Next read word
    always_comb begin
        rd_data_d = rd_en ? mem_q[rd_addr] : rd_data_q;
    end

    // Storage and read register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_data_q <= REGFILE_RESET;
            for (int i = 0; i < (1<<AW); i++) begin
                mem_q[i] <= REGFILE_RESET;
            end
        end else begin
            rd_data_q <= rd_data_d;
            if (wr_en) begin
                mem_q[wr_addr] <= wr_data;
            end
        end
    end
endmodule : msp_regfile

// ---- core/msp_port.sv ----
// Purpose: Slave serial control port of a low-power radio modem
// Assumes: Core clock well above the host shift clock (half period >= 4 cores)
// Notes:   Frame select and data-in pins pass two flip-flops, shift clock three; edges found on the core clock
// What this block does
// - A transaction holds three or more eight-bit bursts
// - Data sampled on shift clock rise, outgoing data changes on fall
// - Every burst moves eight bits, most significant first
// - After the header data flows one way only, never full duplex
// - Read sends device data to host; write stores host data in device
// - Payload is two bytes or more
// - Device is slave only and never drives the shift clock
// - Serial shifting static; internal transfers run on the core clock
// - Trim field bits 15-8 sets reference; zero is highest frequency
// - Clock-out rate 000 passes undivided reference to clock output
// - Internal switch: bias high while transmitting, low while receiving
// - External switch control polarity is selectable
// - Port answers only in idle or higher, dead in hibernate and doze
module msp_port
    import msp_pkg::*;
(
    input  wire logic       clock,                  // Core clock, 10 MHz
    input  wire logic       rst,                    // Async reset, active high
    input  wire logic       frame_select_n,         // Frame select pin, active low
    input  wire logic       host_shift_clock,       // Serial clock from host
    input  wire logic       mosi,                   // Serial data from host
    output logic            miso,                   // Serial data to host
    output logic            miso_oe,                // Drive enable of miso
    input  wire logic       modem_active,           // Modem in idle or higher mode
    input  wire logic       reference_clock,        // 16 MHz reference
    input  wire logic       transmit_active,        // Radio transmitting
    input  wire logic       external_switch_mode,   // Bias drives external switch
    input  wire logic       switch_polarity_invert, // Invert external switch control
    output logic            clock_out_pin,          // Reference clock output
    output logic [7:0]      xtal_trim,              // Crystal warp trim
    output logic [2:0]      clock_out_rate,         // Clock-out rate field
    output logic            antenna_switch_bias     // Antenna switch bias
);
    msp_state_type state_q, state_d;
    logic              fs_s1_q, fs_s1_d, fs_s2_q, fs_s2_d;
    logic              sck_s1_q, sck_s1_d, sck_s2_q, sck_s2_d, sck_s3_q, sck_s3_d;
    logic              mosi_s1_q, mosi_s1_d, mosi_s2_q, mosi_s2_d;
    logic [3:0]        bit_cnt_q, bit_cnt_d;
    logic [DATA_W-1:0] shift_q, shift_d;
    logic [DATA_W-1:0] tx_q, tx_d;
    logic [DATA_W-1:0] ctl_q, ctl_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic              load_q, load_d;
    logic              miso_q, miso_d;
    logic              bias_q, bias_d;
    logic              sck_rise, sck_fall, selected;
    logic              mem_wr_en, mem_rd_en;
    logic [DATA_W-1:0] mem_wr_data, mem_rd_data;
    logic [DATA_W-1:0] word_in;

    // Internal resources other than the clock-out control register
    msp_regfile #(
        .AW (ADDR_W),
        .DW (DATA_W)
    ) u_regfile (
        .clock     (clock),
        .rst       (rst),
        .wr_en     (mem_wr_en),
        .wr_addr   (addr_q),
        .wr_data   (mem_wr_data),
        .rd_en     (mem_rd_en),
        .rd_addr   (addr_d),
        .rd_data_q (mem_rd_data)
    );

    // Edges of the synchronised pins; second and third stages only
    assign sck_rise = sck_s2_q & ~sck_s3_q;
    assign sck_fall = ~sck_s2_q & sck_s3_q;
    assign selected = ~fs_s2_q & modem_active;
    assign word_in  = {shift_q[DATA_W-2:0], mosi_s2_q};

    // Next values of the serial engine
    always_comb begin
        fs_s1_d     = frame_select_n;
        fs_s2_d     = fs_s1_q;
        sck_s1_d    = host_shift_clock;
        sck_s2_d    = sck_s1_q;
        sck_s3_d    = sck_s2_q;
        mosi_s1_d   = mosi;
        mosi_s2_d   = mosi_s1_q;
        state_d     = state_q;
        bit_cnt_d   = bit_cnt_q;
        shift_d     = shift_q;
        tx_d        = tx_q;
        ctl_d       = ctl_q;
        addr_d      = addr_q;
        load_d      = 1'b0;
        miso_d      = miso_q;
        mem_wr_en   = 1'b0;
        mem_wr_data = word_in;
        mem_rd_en   = 1'b0;
        // Word fetched by the previous cycle is moved into the send register
        if (load_q) begin
            tx_d = msp_is_clock_ctl(addr_q) ? ctl_q : mem_rd_data;
        end
        if (!selected) begin
            state_d   = ST_IDLE;
            bit_cnt_d = 4'h0;
            miso_d    = 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    state_d   = ST_HEADER;
                    bit_cnt_d = 4'h0;
                end
                ST_HEADER: begin
                    if (sck_rise) begin
                        shift_d   = word_in;
                        bit_cnt_d = bit_cnt_q + 4'h1;
                        if (bit_cnt_q == HDR_LAST_BIT) begin
                            bit_cnt_d = 4'h0;
                            addr_d    = word_in[ADDR_W-1:0];
                            if (word_in[HDR_RW_BIT]) begin
                                state_d   = ST_READ;
                                mem_rd_en = 1'b1;
                                load_d    = 1'b1;
                            end else begin
                                state_d   = ST_WRITE;
                            end
                        end
                    end
                end
                ST_WRITE: begin
                    // Only host data is taken; miso stays low
                    if (sck_rise) begin
                        shift_d   = word_in;
                        bit_cnt_d = bit_cnt_q + 4'h1;
                        if (bit_cnt_q == WORD_LAST_BIT) begin
                            bit_cnt_d = 4'h0;
                            addr_d    = addr_q + 6'h01;
                            if (msp_is_clock_ctl(addr_q)) begin
                                ctl_d = word_in;
                            end else begin
                                mem_wr_en = 1'b1;
                            end
                        end
                    end
                end
                ST_READ: begin
                    // Host data ignored; words stream out with address advancing
                    if (sck_rise) begin
                        bit_cnt_d = bit_cnt_q + 4'h1;
                        if (bit_cnt_q == WORD_LAST_BIT) begin
                            bit_cnt_d = 4'h0;
                            addr_d    = addr_q + 6'h01;
                            mem_rd_en = 1'b1;
                            load_d    = 1'b1;
                        end
                    end
                    if (sck_fall) begin
                        miso_d = tx_q[WORD_LAST_BIT - bit_cnt_q];
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    // Bias follows the radio direction; inverted only for an external switch
    always_comb begin
        bias_d = transmit_active ^ (external_switch_mode & switch_polarity_invert);
    end

    // State registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fs_s1_q   <= 1'b1;
            fs_s2_q   <= 1'b1;
            sck_s1_q  <= 1'b0;
            sck_s2_q  <= 1'b0;
            sck_s3_q  <= 1'b0;
            mosi_s1_q <= 1'b0;
            mosi_s2_q <= 1'b0;
            state_q   <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q   <= REGFILE_RESET;
            tx_q      <= REGFILE_RESET;
            ctl_q     <= CLOCK_OUT_CONTROL_RESET;
            addr_q    <= 6'h00;
            load_q    <= 1'b0;
            miso_q    <= 1'b0;
            bias_q    <= 1'b0;
        end else begin
            fs_s1_q   <= fs_s1_d;
            fs_s2_q   <= fs_s2_d;
            sck_s1_q  <= sck_s1_d;
            sck_s2_q  <= sck_s2_d;
            sck_s3_q  <= sck_s3_d;
            mosi_s1_q <= mosi_s1_d;
            mosi_s2_q <= mosi_s2_d;
            state_q   <= state_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q   <= shift_d;
            tx_q      <= tx_d;
            ctl_q     <= ctl_d;
            addr_q    <= addr_d;
            load_q    <= load_d;
            miso_q    <= miso_d;
            bias_q    <= bias_d;
        end
    end

    // Pin outputs; miso is driven only during the read data phase
    assign miso                = miso_q;
    assign miso_oe             = (state_q == ST_READ);
    assign xtal_trim           = ctl_q[XTAL_TRIM_MSB:XTAL_TRIM_LSB];
    assign clock_out_rate      = ctl_q[CLOCK_OUT_PIN_RATE_MSB:CLOCK_OUT_PIN_RATE_LSB];
    assign clock_out_pin       = reference_clock &
                                 (clock_out_rate == CLOCK_OUT_PIN_RATE_UNDIVIDED);
    assign antenna_switch_bias = bias_q;
endmodule : msp_port

// ---- sim/msp_port_sva.sv ----
// Purpose: Port checker of the modem serial control port
// Assumes: Host half period of at least six core cycles
// Notes:   Bound to every msp_port instance below
module msp_port_sva
    import msp_pkg::*;
(
    input wire logic       clock,                  // Core clock
    input wire logic       rst,                    // Async reset
    input wire logic       frame_select_n,         // Frame select
    input wire logic       host_shift_clock,       // Shift clock
    input wire logic       mosi,                   // Data in
    input wire logic       miso,                   // Data out
    input wire logic       miso_oe,                // Data out enable
    input wire logic       modem_active,           // Idle or higher
    input wire logic       reference_clock,        // Reference
    input wire logic       transmit_active,        // Transmitting
    input wire logic       external_switch_mode,   // External switch
    input wire logic       switch_polarity_invert, // Switch polarity
    input wire logic       clock_out_pin,          // Clock output
    input wire logic [7:0] xtal_trim,              // Trim field
    input wire logic [2:0] clock_out_rate,         // Rate field
    input wire logic       antenna_switch_bias     // Bias output
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Quiet spans on the frame select and mode pins
    sequence s_desel; frame_select_n [*5]; endsequence
    sequence s_dead; !modem_active [*3]; endsequence
    // Relations between pins over time
    AST_CLOCK_OUT_PIN_PASS: assert property (clock_out_rate == 3'h0 |-> clock_out_pin == reference_clock)
        else $error("clock output not following reference");
    AST_CLOCK_OUT_PIN_GATE: assert property (clock_out_rate != 3'h0 |-> !clock_out_pin)
        else $error("clock output active at other rate");
    AST_BIAS: assert property (!$past(rst) |-> antenna_switch_bias ==
        $past(transmit_active ^ (external_switch_mode & switch_polarity_invert)))
        else $error("antenna bias wrong");
    AST_DESEL: assert property (s_desel |-> !miso_oe && !miso)
        else $error("data out driven while deselected");
    AST_DEAD: assert property (s_dead |-> !miso_oe)
        else $error("port answered while modem inactive");
    AST_MISO_FALL: assert property (miso_oe && $changed(miso) |-> !host_shift_clock)
        else $error("data out changed while shift clock high");
    AST_OE_ROSE: assert property ($rose(miso_oe) |-> !frame_select_n && modem_active)
        else $error("read phase outside a frame");
    AST_QUIET: assert property (!miso_oe [*2] |-> !miso)
        else $error("data out not zero outside read phase");
    AST_TRIM: assert property ($changed({xtal_trim, clock_out_rate}) |-> !$past(frame_select_n))
        else $error("clock control changed outside a frame");
endmodule : msp_port_sva

bind msp_port msp_port_sva u_sva (
    .clock                  (clock),
    .rst                    (rst),
    .frame_select_n         (frame_select_n),
    .host_shift_clock       (host_shift_clock),
    .mosi                   (mosi),
    .miso                   (miso),
    .miso_oe                (miso_oe),
    .modem_active           (modem_active),
    .reference_clock        (reference_clock),
    .transmit_active        (transmit_active),
    .external_switch_mode   (external_switch_mode),
    .switch_polarity_invert (switch_polarity_invert),
    .clock_out_pin          (clock_out_pin),
    .xtal_trim              (xtal_trim),
    .clock_out_rate         (clock_out_rate),
    .antenna_switch_bias    (antenna_switch_bias)
);

// ---- sim/msp_host_model.sv ----
// Purpose: Host serial master driving the modem port
// Assumes: Mode zero clocking, shift clock idles low
// Notes:   Half period hp is set by the bench
module msp_host_model (
    input  wire logic        clock,            // Core clock
    input  wire logic        miso,             // Data from device
    output logic             frame_select_n,   // Frame select, active low
    output logic             host_shift_clock, // Shift clock
    output logic             mosi,             // Data to device
    output logic             word_strobe,      // Read word ready
    output logic      [15:0] word_seen         // Read word
);
    timeunit 1ns;
    timeprecision 1ps;
    int hp = 6; // Half period in core cycles, far below 8 MHz
    initial begin
        frame_select_n = 1'b1;
        host_shift_clock = 1'b0;
        mosi = 1'b0;
        word_strobe = 1'b0;
        word_seen = 16'h0000;
    end
    // One eight-bit burst, top bit first, sampled on the rise
    task automatic send_byte(input logic [7:0] b);
        for (int j = 7; j >= 0; j--) begin
            mosi <= b[j];
            repeat (hp) @(posedge clock);
            host_shift_clock <= 1'b1;
            word_seen <= {word_seen[14:0], miso};
            repeat (hp) @(posedge clock);
            host_shift_clock <= 1'b0;
        end
    endtask : send_byte
    // Whole framed transaction: header then nb payload bytes
    task automatic frame(input logic [7:0] hdr, input int nb, input logic [63:0] wd);
        @(posedge clock);
        frame_select_n <= 1'b0;
        repeat (4) @(posedge clock);
        send_byte(hdr);
        for (int i = 0; i < nb; i++) begin
            send_byte(wd[63-8*i -: 8]);
            if (hdr[7] && i[0]) begin
                word_strobe <= 1'b1;
                @(posedge clock);
                word_strobe <= 1'b0;
            end
        end
        repeat (hp) @(posedge clock);
        frame_select_n <= 1'b1;
        mosi <= ~mosi;
        repeat (6) @(posedge clock);
    endtask : frame
endmodule : msp_host_model

// ---- sim/tb.sv ----
// Purpose: Self-checking bench of the modem serial port
// Assumes: Core clock 10 MHz, reference 16 MHz
// Notes:   Read words are queued and compared by a monitor
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, rst = 1'b1, reference_clock = 1'b0, modem_active = 1'b1;
    logic transmit_active = 1'b0, external_switch_mode = 1'b0, switch_polarity_invert = 1'b0;
    logic frame_select_n, host_shift_clock, mosi, miso, miso_oe, clock_out_pin;
    logic antenna_switch_bias, word_strobe;
    logic [7:0]  xtal_trim;
    logic [2:0]  clock_out_rate;
    logic [15:0] word_seen, rv, w0, w1;
    logic [15:0] exp_q[$];
    int failures = 0, samples_checked = 0, seed = 32'h3321;
    // Clocks
    always #50 clock = ~clock;
    always #31.25 reference_clock = ~reference_clock;
    msp_port dut (
        .clock                  (clock),
        .rst                    (rst),
        .frame_select_n         (frame_select_n),
        .host_shift_clock       (host_shift_clock),
        .mosi                   (mosi),
        .miso                   (miso),
        .miso_oe                (miso_oe),
        .modem_active           (modem_active),
        .reference_clock        (reference_clock),
        .transmit_active        (transmit_active),
        .external_switch_mode   (external_switch_mode),
        .switch_polarity_invert (switch_polarity_invert),
        .clock_out_pin          (clock_out_pin),
        .xtal_trim              (xtal_trim),
        .clock_out_rate         (clock_out_rate),
        .antenna_switch_bias    (antenna_switch_bias)
    );
    msp_host_model host (
        .clock            (clock),
        .miso             (miso),
        .frame_select_n   (frame_select_n),
        .host_shift_clock (host_shift_clock),
        .mosi             (mosi),
        .word_strobe      (word_strobe),
        .word_seen        (word_seen)
    );
    task automatic check(input string nm, input logic [15:0] ex, input logic [15:0] got);
        samples_checked++;
        if (got !== ex) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, ex, got);
        end
    endtask : check
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    // Monitor takes the oldest note for each read word
    always @(posedge clock) begin
        if (word_strobe === 1'b1) begin
            if (exp_q.size() == 0) check("read word count", 16'h0001, 16'h0000);
            else check("read word", exp_q.pop_front(), word_seen);
        end
    end
    // Watchdog
    initial begin
        #2000000;
        failures++;
        print_verdict();
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check("trim reset", 16'h0000, {8'h00, xtal_trim});
        check("rate reset", 16'h0000, {13'h0, clock_out_rate});
        rv = 16'($random(seed));
        rv[2:0] = 3'h5;
        host.frame(8'h0a, 2, {rv, 48'h0});
        check("trim", {8'h00, rv[15:8]}, {8'h00, xtal_trim});
        check("rate", {13'h0, rv[2:0]}, {13'h0, clock_out_rate});
        exp_q.push_back(rv);
        host.frame(8'h8a, 2, {32'($random(seed)), 32'h0});
        $display("test single word done");
        w0 = 16'($random(seed));
        w1 = 16'($random(seed));
        host.hp = 10;
        host.frame(8'h09, 4, {w0, w1, 32'h0});
        host.hp = 6;
        check("burst trim", {8'h00, w1[15:8]}, {8'h00, xtal_trim});
        exp_q.push_back(w0);
        exp_q.push_back(w1);
        host.frame(8'hc9, 4, {32'($random(seed)), 32'($random(seed))});
        $display("test burst done");
        host.frame(8'h0a, 3, {24'h0000ff, 40'h0});
        exp_q.push_back(16'h0000);
        exp_q.push_back(16'h0000);
        host.frame(8'h8a, 4, 64'h0);
        $display("test odd byte done");
        modem_active <= 1'b0;
        host.frame(8'h0a, 2, {16'hffff, 48'h0});
        check("dead trim", 16'h0000, {8'h00, xtal_trim});
        // A read of a stored word while inactive must see an idle output
        exp_q.push_back(16'h0000);
        host.frame(8'h89, 2, 64'h0);
        modem_active <= 1'b1;
        $display("test inactive mode done");
        for (int k = 0; k < 8; k++) begin
            {transmit_active, external_switch_mode, switch_polarity_invert} <= k[2:0];
            repeat (3) @(posedge clock);
            check("bias", {15'h0, k[2] ^ (k[1] & k[0])}, {15'h0, antenna_switch_bias});
        end
        $display("test bias done");
        repeat (4) @(posedge clock);
        check("pending reads", 16'h0000, 16'(exp_q.size()));
        print_verdict();
    end
endmodule : tb
